// *** hdl/csf_flag_calc.sv ***
`timescale 1ns/10ps
module csf_flag_calc
  import csf_pkg::*;
(
  // operation and operands
  input wire csf_pkg::csf_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  // new flag values and which ones to load
  output logic carry_out,
  output logic aux_out,
  output logic excess_out,
  output logic load_arith_out,
  output logic load_excess_out
);
  logic [8:0] sum;
  logic [4:0] low;
  logic [15:0] prod;
  logic cin;
  always_comb
  begin
    cin = (op_in == CSF_OP_ADD) ? 1'b0 : carry_in;
    carry_out = 1'b0;
    aux_out = 1'b0;
    excess_out = 1'b0;
    load_arith_out = 1'b0;
    load_excess_out = 1'b0;
    // widen before multiplying so the high byte of the product is kept
    prod = 16'(a_in) * 16'(b_in);
    sum = 9'h000;
    low = 5'h00;
    case (op_in)
      CSF_OP_ADD, CSF_OP_SUM_WITH_CARRY:
      begin
        sum = 9'(a_in) + 9'(b_in) + 9'(cin);
        low = 5'(a_in[3:0]) + 5'(b_in[3:0]) + 5'(cin);
        carry_out = sum[8]; // RL2
        aux_out = low[4]; // RL3
        excess_out = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]); // RL6
        load_arith_out = 1'b1;
        load_excess_out = 1'b1;
      end
      CSF_OP_SUBTRACT_BORROW:
      begin
        sum = 9'(a_in) - 9'(b_in) - 9'(cin);
        low = 5'(a_in[3:0]) - 5'(b_in[3:0]) - 5'(cin);
        carry_out = sum[8]; // RL2
        aux_out = low[4]; // RL3
        excess_out = (a_in[7] != b_in[7]) && (sum[7] != a_in[7]); // RL6
        load_arith_out = 1'b1;
        load_excess_out = 1'b1;
      end
      CSF_OP_PRODUCT:
      begin
        // carry is cleared by multiply as an arithmetic operation
        excess_out = prod > CSF_BYTE_MAX; // RL7 RL9
        load_arith_out = 1'b1;
        load_excess_out = 1'b1;
      end
      CSF_OP_DIV:
      begin
        excess_out = (b_in == 8'h00); // RL8 RL9
        load_arith_out = 1'b1;
        load_excess_out = 1'b1;
      end
      default:
      begin
        load_arith_out = 1'b0;
      end
    endcase
  end
endmodule

// *** hdl/csf_parity.sv ***
`timescale 1ns/10ps
module csf_parity
(
  // accumulator
  input wire logic [7:0] acc_in,
  // odd ones count
  output logic odd_out
);
  assign odd_out = ^acc_in; // RL10 RL12
endmodule

// *** hdl/csf_pkg.sv ***
// Operation
// (RL1) status word sits at direct address D0, bit addressable, resets to zero
// (RL2) bit 7 set on carry or borrow, cleared by other arithmetic
// (RL3) bit 6 set on carry into or borrow from upper nibble, else cleared
// (RL4) bits 5 and 1 change only by software writes
// (RL5) bits 4:3 pick register bank, base address is field times eight
// (RL6) bit 2 set on signed overflow of add, add with carry, subtract borrow
// (RL7) bit 2 set when product exceeds 255
// (RL8) bit 2 set on divide by zero
// (RL9) those five instructions clear bit 2 otherwise
// (RL10) bit 0 read only, one when accumulator has odd ones count
// (RL11) direct addresses from 80 reach registers, indirect ones reach data memory
// (RL12) parity follows accumulator continuously, writes to bit 0 ignored
package csf_pkg;
  localparam logic [7:0] CSF_STATUS_ADDR = 8'hD0;
  localparam logic [7:0] CSF_SFR_BASE = 8'h80;
  localparam logic [7:0] CSF_STATUS_RESET = 8'h00;
  localparam int CSF_CARRY_BIT = 7;
  localparam int CSF_AUX_BIT = 6;
  localparam int CSF_USER0_BIT = 5;
  localparam int CSF_BANK_HI_BIT = 4;
  localparam int CSF_BANK_LO_BIT = 3;
  localparam int CSF_EXCESS_BIT = 2;
  localparam int CSF_USER1_BIT = 1;
  localparam int CSF_PARITY_BIT = 0;
  localparam logic [15:0] CSF_BYTE_MAX = 16'h00FF;
  localparam int CSF_BANK_SHIFT = 3;

  typedef enum logic [2:0]
  {
    CSF_OP_NONE = 3'b000,
    CSF_OP_ADD = 3'b001,
    CSF_OP_SUM_WITH_CARRY = 3'b010,
    CSF_OP_SUBTRACT_BORROW = 3'b011,
    CSF_OP_PRODUCT = 3'b100,
    CSF_OP_DIV = 3'b101,
    CSF_OP_OTHER = 3'b110
  } csf_op_e;
endpackage

// *** hdl/csf_status_word.sv ***
`timescale 1ns/10ps
module csf_status_word
  import csf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // direct register access
  input wire logic [7:0] addr_in,
  input wire logic direct_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  input wire logic bit_wr_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic bit_val_in,
  // arithmetic outcome
  input wire csf_pkg::csf_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [7:0] acc_in,
  // results
  output logic [7:0] rdata_out,
  output logic carry_out,
  output logic [4:0] bank_base_out,
  output logic [7:0] status_out
);
  import csf_pkg::*;

  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] acc_q;
  logic parity;
  logic sel;
  logic c_new;
  logic aux_new;
  logic excess_new;
  logic ld_arith;
  logic ld_excess;

  csf_parity u_parity
  (
    .acc_in(acc_q),
    .odd_out(parity)
  );

  csf_flag_calc u_calc
  (
    .op_in(op_in),
    .a_in(a_in),
    .b_in(b_in),
    .carry_in(status[CSF_CARRY_BIT]),
    .carry_out(c_new),
    .aux_out(aux_new),
    .excess_out(excess_new),
    .load_arith_out(ld_arith),
    .load_excess_out(ld_excess)
  );

  // only direct accesses in the register range reach the word
  assign sel = direct_in && (addr_in >= CSF_SFR_BASE) && (addr_in == CSF_STATUS_ADDR); // RL11 RL1

  // the instruction outcome takes priority over a software write in the same cycle
  always_comb
  begin
    next_status = status;
    if (sel && wr_in)
    begin
      next_status = wdata_in; // RL4
    end
    if (sel && bit_wr_in)
    begin
      next_status[bit_sel_in] = bit_val_in; // RL1
    end
    if (ld_arith)
    begin
      next_status[CSF_CARRY_BIT] = c_new; // RL2
      next_status[CSF_AUX_BIT] = aux_new; // RL3
    end
    if (ld_excess)
    begin
      next_status[CSF_EXCESS_BIT] = excess_new; // RL6 RL9
    end
    next_status[CSF_PARITY_BIT] = 1'b0; // RL12
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      status <= CSF_STATUS_RESET; // RL1
    end
    else
    begin
      status <= next_status;
    end
  end

  // accumulator is registered so parity comes from a flop; lags acc by one cycle
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      acc_q <= 8'h00;
    end
    else
    begin
      acc_q <= acc_in; // RL12
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rdata_out <= 8'h00;
      carry_out <= 1'b0;
      bank_base_out <= 5'h00;
      status_out <= CSF_STATUS_RESET;
    end
    else
    begin
      rdata_out <= sel ? {next_status[7:1], ^acc_in} : 8'h00; // RL10
      carry_out <= next_status[CSF_CARRY_BIT];
      bank_base_out <= 5'({next_status[CSF_BANK_HI_BIT:CSF_BANK_LO_BIT], 3'b000}); // RL5
      status_out <= {next_status[7:1], ^acc_in}; // RL10
    end
  end

  wire [7:0] word_now = {status[7:1], parity};

  user_bits_a: assert property (@(posedge clk_in) disable iff (reset_in)
    !(sel && (wr_in || bit_wr_in)) |=> ({status[5], status[1]} == $past({status[5], status[1]}))) // RL4
    else $error("user flag changed without a write");
  parity_out_a: assert property (@(posedge clk_in) disable iff (reset_in)
    status_out[0] == ^acc_q) // RL10
    else $error("parity flag wrong");
  parity_ro_a: assert property (@(posedge clk_in) disable iff (reset_in) status[0] == 1'b0) // RL12
    else $error("parity bit stored");
  bank_base_a: assert property (@(posedge clk_in) disable iff (reset_in)
    bank_base_out == {status[4:3], 3'b000}) // RL5
    else $error("bank base mismatch");
  div_zero_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_DIV && b_in == 8'h00) |=> status[2]) // RL8
    else $error("divide by zero not flagged");
  mul_big_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_PRODUCT) |=> (status[2] == ($past(a_in) * $past(b_in) > 255) && !status[7])) // RL7
    else $error("multiply overflow wrong");
  add_carry_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_ADD) |=> (status[7] == (({1'b0, $past(a_in)} + {1'b0, $past(b_in)}) > 9'h0FF))) // RL2
    else $error("carry wrong after add");
  add_aux_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_ADD) |=> (status[6] == (($past(a_in[3:0]) + $past(b_in[3:0])) > 5'h0F))) // RL3
    else $error("aux carry wrong after add");
  add_ovf_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_ADD && a_in[7] == b_in[7]) |=> (status[2] == ($past(a_in[7]) != 8'($past(a_in) + $past(b_in)) >> 7))) // RL6
    else $error("signed overflow wrong");
  clear_ovf_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (op_in == CSF_OP_DIV && b_in != 8'h00) |=> !status[2]) // RL9
    else $error("overflow not cleared");
  reset_word_a: assert property (@(posedge clk_in) $past(reset_in) |-> status == 8'h00) // RL1
    else $error("word not zero after reset");
  other_addr_a: assert property (@(posedge clk_in) disable iff (reset_in)
    (!direct_in && addr_in == CSF_STATUS_ADDR && wr_in && op_in == CSF_OP_NONE) |=> $stable(word_now[7:1])) // RL11
    else $error("indirect access reached word");
endmodule

// *** testbench/csf_status_word_tb.sv ***
`timescale 1ns/10ps
module testbench;
  import csf_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic direct_in = 1'b0;
  logic wr_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic bit_wr_in = 1'b0;
  logic [2:0] bit_sel_in = 3'h0;
  logic bit_val_in = 1'b0;
  csf_op_e op_in = CSF_OP_NONE;
  logic [7:0] a_in = 8'h00;
  logic [7:0] b_in = 8'h00;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] rdata_out;
  logic carry_out;
  logic [4:0] bank_base_out;
  logic [7:0] status_out;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // flag outcomes worked out by hand; user bits 5,4,3,1 stay at 3A throughout
  csf_op_e ops [9] = '{CSF_OP_ADD, CSF_OP_ADD, CSF_OP_SUM_WITH_CARRY, CSF_OP_SUBTRACT_BORROW,
    CSF_OP_SUBTRACT_BORROW, CSF_OP_PRODUCT, CSF_OP_PRODUCT, CSF_OP_DIV, CSF_OP_OTHER};
  logic [7:0] opa [9] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h10, 8'h0F, 8'h05, 8'hFF};
  logic [7:0] opb [9] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h10, 8'h11, 8'h00, 8'hFF};
  logic [7:0] opx [9] = '{8'h7E, 8'hFA, 8'h3A, 8'hFA, 8'h7E, 8'h3E, 8'h3A, 8'h3E, 8'h3E};

  always #5 clk_in = ~clk_in;

  csf_status_word DUT
  (
    .clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .direct_in(direct_in),
    .wr_in(wr_in), .wdata_in(wdata_in), .bit_wr_in(bit_wr_in), .bit_sel_in(bit_sel_in),
    .bit_val_in(bit_val_in), .op_in(op_in), .a_in(a_in), .b_in(b_in), .acc_in(acc_in),
    .rdata_out(rdata_out), .carry_out(carry_out), .bank_base_out(bank_base_out),
    .status_out(status_out)
  );

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one access per call; strobes drop a cycle later so consecutive calls never collide
  task automatic cyc(input logic dir, input logic [7:0] addr, input logic wr, input logic [7:0] wd,
    input logic bw, input logic [2:0] bs, input csf_op_e op, input logic [7:0] a, input logic [7:0] b);
    direct_in = dir;
    addr_in = addr;
    wr_in = wr;
    wdata_in = wd;
    bit_wr_in = bw;
    bit_sel_in = bs;
    bit_val_in = wd[0];
    op_in = op;
    a_in = a;
    b_in = b;
    @(negedge clk_in);
    wr_in = 1'b0;
    bit_wr_in = 1'b0;
    op_in = CSF_OP_NONE;
    @(negedge clk_in);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles >= 1000)
    begin
      num_errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (8) @(negedge clk_in);
    reset_in = 1'b0;
    check("reset word", CSF_STATUS_RESET, status_out);
    check("reset bank", 8'h00, {3'h0, bank_base_out});
    cyc(1'b1, CSF_STATUS_ADDR, 1'b1, 8'hFF, 1'b0, 3'h0, CSF_OP_NONE, 8'h00, 8'h00);
    check("word after write", 8'hFE, status_out);
    check("read data", 8'hFE, rdata_out);
    check("carry", 8'h01, {7'h00, carry_out});
    cyc(1'b0, CSF_STATUS_ADDR, 1'b1, 8'h00, 1'b0, 3'h0, CSF_OP_NONE, 8'h00, 8'h00);
    check("indirect write", 8'hFE, status_out);
    check("indirect read", 8'h00, rdata_out);
    cyc(1'b1, 8'hD1, 1'b1, 8'h00, 1'b0, 3'h0, CSF_OP_NONE, 8'h00, 8'h00);
    check("other address", 8'hFE, status_out);
    for (int i = 0; i < 4; i++)
    begin
      cyc(1'b1, CSF_STATUS_ADDR, 1'b1, 8'(i << 3), 1'b0, 3'h0, CSF_OP_NONE, 8'h00, 8'h00);
      check("bank base", 8'(i * 8), {3'h0, bank_base_out});
    end
    cyc(1'b1, CSF_STATUS_ADDR, 1'b0, 8'h01, 1'b1, 3'h5, CSF_OP_NONE, 8'h00, 8'h00);
    check("bit 5 set", 8'h38, status_out);
    cyc(1'b1, CSF_STATUS_ADDR, 1'b0, 8'h01, 1'b1, 3'h0, CSF_OP_NONE, 8'h00, 8'h00);
    check("bit 0 write", 8'h38, status_out);
    cyc(1'b1, CSF_STATUS_ADDR, 1'b0, 8'h01, 1'b1, 3'h1, CSF_OP_NONE, 8'h00, 8'h00);
    check("bit 1 set", 8'h3A, status_out);
    for (int i = 0; i < 9; i++)
    begin
      cyc(1'b1, CSF_STATUS_ADDR, 1'b0, 8'h00, 1'b0, 3'h0, ops[i], opa[i], opb[i]);
      check(ops[i].name(), opx[i], status_out);
      check("carry out", {7'h00, opx[i][7]}, {7'h00, carry_out});
    end
    cyc(1'b1, CSF_STATUS_ADDR, 1'b0, 8'h00, 1'b0, 3'h0, CSF_OP_DIV, 8'h05, 8'h01);
    check("divide nonzero", 8'h3A, status_out);
    acc_in = 8'h07;
    @(negedge clk_in);
    check("odd parity", 8'h3B, status_out);
    acc_in = 8'h03;
    @(negedge clk_in);
    check("even parity", 8'h3A, status_out);
    cyc(1'b1, CSF_STATUS_ADDR, 1'b1, 8'hFF, 1'b0, 3'h0, CSF_OP_ADD, 8'h00, 8'h00);
    check("write with add", 8'h3A, status_out);
    test_done();
  end
endmodule
